// ===== shared/reset_gen_defines.vh
/*
  Constants for the reset generator and active-hold timers.
  Assumes a 20 MHz ref_clk; timebase tick is 1 us.
*/
`ifndef RESET_GEN_DEFINES_VH
`define RESET_GEN_DEFINES_VH

// ****************************************
// Clock and timebase
// ****************************************
`define CLK_PERIOD_NS 50
`define TICK_NS 1000
`define TICK_CYCLES (`TICK_NS / `CLK_PERIOD_NS)
`define TICK_CNT_W 5

// ****************************************
// Delay field layout (ms per step)
// ****************************************
`define DEL_MIN_MS 1
`define DEL_MAX_MS 45
`define DELP_MAX_MS 10
`define DEL_FIELD_W 6
`define DELP_FIELD_W 4
`define DEL_RESET_VAL 6'h0A
`define DELP_RESET_VAL 4'h1
`define TICKS_PER_MS 26'h03e8

// ****************************************
// Hold timers, in timebase ticks
// ****************************************
`define RST_POFF_US 26'h1_86a0
`define WACK_US 26'h7_a120
`define POFF_DEL_US 26'h4e20
`define TMR_W 26

`endif

// ===== logic/hold_timer.v
/*
  Retriggerable one-shot timer counted in timebase ticks.
  Assumes tick is a one-cycle pulse in the ref_clk domain.
*/
`timescale 1ns/1ns
module hold_timer
#(
  parameter W = 26
)
(
  input wire ref_clk,
  input wire rst,
  input wire start,
  input wire stop,
  input wire tick,
  input wire [W-1:0] limit,
  output wire running
);
  reg [W-1:0] cnt_ff; // Ticks elapsed
  reg run_ff; // Timer active
  reg [W-1:0] nxt_cnt;
  reg nxt_run;

  // Next state: start restarts from zero, stop wins over running
  always @*
  begin
    nxt_cnt = cnt_ff;
    nxt_run = run_ff;
    if (start)
    begin
      nxt_cnt = {W{1'b0}};
      nxt_run = 1'b1;
    end
    else if (stop)
      nxt_run = 1'b0;
    else if (run_ff && tick)
    begin
      if (cnt_ff + 1'b1 >= limit)
        nxt_run = 1'b0; // Expired
      nxt_cnt = cnt_ff + 1'b1;
    end
  end

  // State registers
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_ff <= {W{1'b0}};
      run_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      run_ff <= nxt_run;
    end
  end

  assign running = run_ff;
endmodule // hold_timer

// ===== logic/reset_generator_active_hold.v
/*
  Reset generator with wake-dependent release delay and Active Mode hold timers.
  Assumes supply comparator flags and pin levels are synchronous to ref_clk.
*/
// Operation
// RL1 - Hold reset low until supply rises, delay
// RL2 - Supply falling trip asserts reset, marks invalid
// RL3 - Reset line level readable as status bit
// RL4 - Network wake uses network delay, else ordinary
// RL5 - Delays programmable 1-45 ms and 1-10 ms
// RL6 - Open-drain reset; detect external low drive
// RL7 - Reset low forces soft transmit bit set
// RL8 - Reset low keeps hold bit cleared
// RL9 - Reset low disables LIN driver
// RL10 - Reset assertion starts low-hold timer forcing active
// RL11 - Release restarts wake-ack timer until acknowledged
// RL12 - Grace timer after power-off release or hold clear
// RL13 - Supply invalid and reset ignores power-off request
// RL14 - Host acknowledges before wake-ack timer expires
// RL15 - Power-off request low keeps Active Mode
// RL16 - Supply invalid clears the hold bit
// RL17 - Active forced by any timer, request, hold
// RL18 - Timers count internal ticks, restart on retrigger
`timescale 1ns/1ns
`include "reset_gen_defines.vh"
module reset_generator_active_hold
(
  input wire ref_clk,
  input wire rst,
  input wire supply_above_rise, // Supply sense above rising trip
  input wire supply_below_fall, // Supply sense below falling trip
  input wire network_wake, // Active Mode entered by network activity
  input wire [5:0] reset_release_delay, // Ordinary delay in ms
  input wire [3:0] network_wake_reset_delay, // Network-wake delay in ms
  input wire reset_line_in, // Sensed level of reset line
  input wire power_off_request, // Low keeps Active Mode
  input wire hold_set, // Software sets hold bit
  input wire hold_clr, // Software clears hold bit
  input wire lin_soft_tx_wr, // Software write strobe to transmit bit
  input wire lin_soft_tx_wdata, // Software write value
  output reg reset_line_out, // Always low when driven
  output reg reset_line_oe, // High while pulling line low
  output reg line_reset_level_bit, // Status: present line level
  output reg lin_soft_transmit_bit, // Soft transmit bit
  output reg hold_bit, // Active Mode hold bit
  output reg lin_driver_en, // LIN driver enable
  output reg supply_invalid, // Supply invalid condition
  output reg force_active // Active Mode forced
);

  // ****************************************
  // Sequencer states
  // ****************************************
  localparam ST_HOLD = 2'd0; // Driving low, waiting supply
  localparam ST_DELAY = 2'd1; // Supply good, counting release delay
  localparam ST_RUN = 2'd2; // Released

  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [`TICK_CNT_W-1:0] pre_ff; // Prescaler to 1 us tick
  reg tick_ff;
  reg [`TMR_W-1:0] del_cnt_ff; // Release delay counter
  reg [`TMR_W-1:0] nxt_del_cnt;
  reg [`TMR_W-1:0] del_limit_ff; // Latched delay target
  reg [`TMR_W-1:0] nxt_del_limit;
  reg line_low_ff; // Previous sampled low level
  reg poff_ff; // Previous effective request low
  reg hold_prev_ff; // Previous hold bit
  reg inval_ff; // Supply invalid register
  wire line_low; // Line seen low now
  wire poff_ignored; // Request input masked
  wire poff_active; // Request effectively low
  wire rst_poff_run;
  wire wack_run;
  wire grace_run;
  wire rst_poff_start; // Line just seen low
  wire wack_start; // Line just seen released
  wire grace_start; // Request released or hold bit dropped
  wire [5:0] del_ms_clamped;
  wire [3:0] delp_ms_clamped;

  assign line_low = ~reset_line_in;
  assign poff_ignored = inval_ff & line_low; // RL13
  assign poff_active = ~power_off_request & ~poff_ignored; // RL15
  // Starts also feed force_active, so a hold shows one cycle after its cause
  assign rst_poff_start = line_low & ~line_low_ff; // RL10
  assign wack_start = ~line_low & line_low_ff; // RL11
  assign grace_start = (poff_ff & ~poff_active) | (hold_prev_ff & ~hold_bit); // RL12

  // Clamp fields into their documented ranges
  assign del_ms_clamped = (reset_release_delay < `DEL_MIN_MS) ? 6'd1 :
                          (reset_release_delay > `DEL_MAX_MS) ? 6'd45 : reset_release_delay; // RL5
  assign delp_ms_clamped = (network_wake_reset_delay < `DEL_MIN_MS) ? 4'd1 :
                           (network_wake_reset_delay > `DELP_MAX_MS) ? 4'd10 : network_wake_reset_delay; // RL5

  // ****************************************
  // Timebase
  // ****************************************
  // One tick per microsecond; all timers count these
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pre_ff <= {`TICK_CNT_W{1'b0}};
      tick_ff <= 1'b0;
    end
    else if (pre_ff == `TICK_CYCLES - 1)
    begin
      pre_ff <= {`TICK_CNT_W{1'b0}};
      tick_ff <= 1'b1; // RL18
    end
    else
    begin
      pre_ff <= pre_ff + 1'b1;
      tick_ff <= 1'b0;
    end
  end

  // ****************************************
  // Reset sequencer
  // ****************************************
  // Delay chosen by wake cause, latched when supply becomes good
  always @*
  begin
    nxt_state = state_ff;
    nxt_del_cnt = del_cnt_ff;
    nxt_del_limit = del_limit_ff;
    case (state_ff)
      ST_HOLD:
      begin
        if (supply_above_rise)
        begin
          nxt_state = ST_DELAY; // RL1
          nxt_del_cnt = {`TMR_W{1'b0}};
          if (network_wake)
            nxt_del_limit = delp_ms_clamped * `TICKS_PER_MS; // RL4
          else
            nxt_del_limit = del_ms_clamped * `TICKS_PER_MS; // RL4
        end
      end
      ST_DELAY:
      begin
        if (supply_below_fall)
          nxt_state = ST_HOLD; // RL2
        else if (tick_ff)
        begin
          nxt_del_cnt = del_cnt_ff + 1'b1;
          if (del_cnt_ff + 1'b1 >= del_limit_ff)
            nxt_state = ST_RUN; // RL1
        end
      end
      ST_RUN:
      begin
        if (supply_below_fall)
          nxt_state = ST_HOLD; // RL2
      end
      default:
        nxt_state = ST_HOLD;
    endcase
  end

  // Sequencer registers
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff <= ST_HOLD;
      del_cnt_ff <= {`TMR_W{1'b0}};
      del_limit_ff <= {`TMR_W{1'b0}};
      inval_ff <= 1'b1;
    end
    else
    begin
      state_ff <= nxt_state;
      del_cnt_ff <= nxt_del_cnt;
      del_limit_ff <= nxt_del_limit;
      // Invalid from falling trip until rising trip seen
      if (supply_below_fall)
        inval_ff <= 1'b1; // RL2
      else if (supply_above_rise)
        inval_ff <= 1'b0;
    end
  end

  // ****************************************
  // Hold timers
  // ****************************************
  // Edge history; external lows count the same as our own
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      line_low_ff <= 1'b0; // Power-up low counts as an assertion
      poff_ff <= 1'b0;
      hold_prev_ff <= 1'b0;
    end
    else
    begin
      line_low_ff <= line_low; // RL6
      poff_ff <= poff_active;
      hold_prev_ff <= hold_bit;
    end
  end

  // Started on reset assertion, ends on expiry or line release
  hold_timer #(.W(`TMR_W)) u_rst_poff
  (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(rst_poff_start), // RL10
    .stop(~line_low),
    .tick(tick_ff),
    .limit(`RST_POFF_US),
    .running(rst_poff_run)
  );

  // Restarted on release; acknowledge stops it
  hold_timer #(.W(`TMR_W)) u_wack
  (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(wack_start), // RL11
    .stop(poff_active | hold_bit | line_low), // RL14
    .tick(tick_ff),
    .limit(`WACK_US),
    .running(wack_run)
  );

  // Grace after request release or hold clear
  hold_timer #(.W(`TMR_W)) u_grace
  (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(grace_start), // RL12
    .stop(poff_active | hold_bit),
    .tick(tick_ff),
    .limit(`POFF_DEL_US),
    .running(grace_run)
  );

  // ****************************************
  // Outputs and fail-safe actions
  // ****************************************
  // Registered outputs; reset-low overrides software writes
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      reset_line_out <= 1'b0;
      reset_line_oe <= 1'b1;
      line_reset_level_bit <= 1'b0;
      lin_soft_transmit_bit <= 1'b1;
      hold_bit <= 1'b0;
      lin_driver_en <= 1'b0;
      supply_invalid <= 1'b1;
      force_active <= 1'b1;
    end
    else
    begin
      reset_line_out <= 1'b0; // RL6
      reset_line_oe <= (nxt_state != ST_RUN); // RL1 RL2 RL6
      line_reset_level_bit <= reset_line_in; // RL3
      // Same next value as inval_ff, so the flag shows one cycle after the trip
      supply_invalid <= supply_below_fall | (inval_ff & ~supply_above_rise); // RL2
      lin_driver_en <= ~line_low; // RL9
      if (line_low)
        lin_soft_transmit_bit <= 1'b1; // RL7
      else if (lin_soft_tx_wr)
        lin_soft_transmit_bit <= lin_soft_tx_wdata;
      if (line_low | inval_ff)
        hold_bit <= 1'b0; // RL8 RL16
      else if (hold_set)
        hold_bit <= 1'b1;
      else if (hold_clr)
        hold_bit <= 1'b0;
      force_active <= rst_poff_run | wack_run | grace_run | rst_poff_start | wack_start | grace_start |
                      poff_active | hold_bit; // RL17
    end
  end

endmodule // reset_generator_active_hold

// ===== verif/reset_gen_chk.sv
/* Port checker for the reset generator.
   Assumes it is bound onto the design top by tb. */
`timescale 1ns/1ns
module reset_gen_chk
(
  input wire ref_clk,
  input wire rst,
  input wire supply_below_fall,
  input wire reset_line_in,
  input wire reset_line_out,
  input wire reset_line_oe,
  input wire line_reset_level_bit,
  input wire lin_soft_transmit_bit,
  input wire hold_bit,
  input wire lin_driver_en,
  input wire supply_invalid,
  input wire force_active
);
  // **********
  // Assertions
  // **********
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_out_low_only: assert property (reset_line_oe |-> !reset_line_out)
    else $error("reset line driven high");
  chk_fall_drives: assert property (supply_below_fall |=> reset_line_oe && supply_invalid)
    else $error("falling trip did not assert reset");
  chk_level_tracks: assert property (!$past(rst) |-> line_reset_level_bit == $past(reset_line_in))
    else $error("status bit does not follow line");
  chk_tx_forced: assert property (!reset_line_in |=> lin_soft_transmit_bit)
    else $error("transmit bit not forced");
  chk_hold_cleared: assert property (!reset_line_in |=> !hold_bit)
    else $error("hold bit set while line low");
  chk_driver_off: assert property (!reset_line_in |=> !lin_driver_en)
    else $error("driver on while line low");
  chk_low_hold: assert property ($fell(reset_line_in) |=> force_active [*8])
    else $error("active not held after assertion");
  chk_wack_hold: assert property ($rose(reset_line_in) |=> force_active [*8])
    else $error("active not held after release");
  chk_release_valid: assert property ($fell(reset_line_oe) |-> !supply_invalid)
    else $error("release while supply invalid");
  chk_inval_hold: assert property (supply_invalid |=> !hold_bit)
    else $error("hold bit set while supply invalid");
  chk_grace_hold: assert property ($fell(hold_bit) |=> force_active [*8])
    else $error("active not held after hold clear");
  // Main scenarios reached
  cov_release: cover property ($fell(reset_line_oe));
  cov_ext_low: cover property ($fell(reset_line_in) && !reset_line_oe);
  cov_hold: cover property ($rose(hold_bit));
endmodule // reset_gen_chk

// ===== verif/host_ctrl_model.sv
/* Host controller beside the reset line.
   Assumes the line has a pull-up and power_off_request too. */
`timescale 1ns/1ns
module host_ctrl_model
#(
  parameter ACK_DLY = 40
)
(
  input wire ref_clk,
  input wire rst,
  input wire reset_line_oe,
  input wire ext_pull,
  output wire reset_line_in,
  output wire power_off_request
);
  // **********
  // Wire and acknowledge
  // **********
  reg [15:0] cnt_ff; // Cycles since line release
  reg por_ff; // Request level, pulled up when idle
  // Wired line: low if any party pulls
  assign reset_line_in = !(reset_line_oe || ext_pull);
  assign power_off_request = por_ff;
  // Host pulls request low some time after release
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_ff <= 16'h0000;
      por_ff <= 1'b1;
    end
    else if (!reset_line_in)
    begin
      cnt_ff <= 16'h0000;
      por_ff <= 1'b1;
    end
    else if (cnt_ff == ACK_DLY)
      por_ff <= 1'b0;
    else
      cnt_ff <= cnt_ff + 16'h0001;
  end
endmodule // host_ctrl_model

// ===== verif/tb.sv
/* Self-checking bench for the reset generator.
   Assumes the selected delay is 1 ms so each release takes 20000 cycles. */
`timescale 1ns/1ns
module tb;
  // **********
  // Signals
  // **********
  reg ref_clk, rst, supply_above_rise, supply_below_fall, network_wake;
  reg [5:0] reset_release_delay;
  reg [3:0] network_wake_reset_delay;
  reg hold_set, hold_clr, lin_soft_tx_wr, lin_soft_tx_wdata, ext_pull;
  wire reset_line_in, power_off_request, reset_line_out, reset_line_oe, line_reset_level_bit;
  wire lin_soft_transmit_bit, hold_bit, lin_driver_en, supply_invalid, force_active;
  wire [6:0] obs = {force_active, supply_invalid, lin_driver_en, hold_bit, lin_soft_transmit_bit,
    line_reset_level_bit, reset_line_oe};
  int num_errors = 0, checks_done = 0, cnt;
  logic [31:0] seed = 32'h0000_2be7;
  logic [6:0] q[$]; // Expected output vectors
  reset_generator_active_hold u_dut (.ref_clk(ref_clk), .rst(rst), .supply_above_rise(supply_above_rise),
    .supply_below_fall(supply_below_fall), .network_wake(network_wake),
    .reset_release_delay(reset_release_delay), .network_wake_reset_delay(network_wake_reset_delay),
    .reset_line_in(reset_line_in), .power_off_request(power_off_request), .hold_set(hold_set),
    .hold_clr(hold_clr), .lin_soft_tx_wr(lin_soft_tx_wr), .lin_soft_tx_wdata(lin_soft_tx_wdata),
    .reset_line_out(reset_line_out), .reset_line_oe(reset_line_oe),
    .line_reset_level_bit(line_reset_level_bit), .lin_soft_transmit_bit(lin_soft_transmit_bit),
    .hold_bit(hold_bit), .lin_driver_en(lin_driver_en), .supply_invalid(supply_invalid),
    .force_active(force_active));
  host_ctrl_model #(.ACK_DLY(40)) u_host (.ref_clk(ref_clk), .rst(rst), .reset_line_oe(reset_line_oe),
    .ext_pull(ext_pull), .reset_line_in(reset_line_in), .power_off_request(power_off_request));
  // **********
  // Helpers
  // **********
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task check(input logic [6:0] seen, input logic [6:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] outputs expected %b seen %b", exp, seen);
    end
  endtask
  task close_out;
    if (num_errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Count cycles until the device lets go; bounded
  task wait_release(input int lo, input int hi);
    cnt = 0;
    while (reset_line_oe !== 1'b0 && cnt < hi)
    begin
      @(negedge ref_clk);
      cnt++;
    end
    if (cnt >= hi)
      num_errors++;
    else
      check({6'h00, cnt >= lo}, 7'h01);
  endtask
  // Let an edge land, then queue the expected outputs
  task settle(input logic [6:0] e);
    repeat (3) @(posedge ref_clk);
    q.push_back(e);
  endtask
  // Watcher: compare once each edge's updates have landed
  always @(negedge ref_clk)
    while (q.size() > 0)
      check(obs, q.pop_front());
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // **********
  // Main sequence
  // **********
  initial
  begin
    {rst, supply_above_rise, supply_below_fall, network_wake} = 4'h8;
    reset_release_delay = 6'h01;
    network_wake_reset_delay = 4'h0; // Below range, clamps to 1 ms
    {hold_set, hold_clr, lin_soft_tx_wr, lin_soft_tx_wdata, ext_pull} = 5'h00;
    repeat (20) @(posedge ref_clk);
    q.push_back(7'b1100101);
    @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    supply_above_rise <= 1'b1;
    wait_release(19950, 20100);
    seed = xs(seed);
    settle(7'b1010110);
    hold_set <= 1'b1;
    lin_soft_tx_wr <= 1'b1;
    lin_soft_tx_wdata <= seed[0];
    @(posedge ref_clk);
    {hold_set, lin_soft_tx_wr} <= 2'b00;
    settle({3'b101, 1'b1, seed[0], 2'b10});
    hold_clr <= 1'b1;
    @(posedge ref_clk);
    hold_clr <= 1'b0;
    settle({3'b101, 1'b0, seed[0], 2'b10});
    // Write lands with the external pull; the forced value must win
    ext_pull <= 1'b1;
    lin_soft_tx_wr <= 1'b1;
    lin_soft_tx_wdata <= 1'b0;
    @(posedge ref_clk);
    lin_soft_tx_wr <= 1'b0;
    settle(7'b1000100);
    ext_pull <= 1'b0;
    settle(7'b1010110);
    supply_above_rise <= 1'b0;
    supply_below_fall <= 1'b1;
    settle(7'b1100101);
    // Hold request while supply invalid is refused
    hold_set <= 1'b1;
    @(posedge ref_clk);
    hold_set <= 1'b0;
    settle(7'b1100101);
    seed = xs(seed);
    supply_below_fall <= 1'b0;
    network_wake <= 1'b1;
    reset_release_delay <= seed[5:0] | 6'h02;
    @(posedge ref_clk);
    supply_above_rise <= 1'b1;
    wait_release(19950, 20100);
    close_out;
  end
endmodule // tb
bind reset_generator_active_hold reset_gen_chk u_chk (.ref_clk(ref_clk), .rst(rst),
  .supply_below_fall(supply_below_fall), .reset_line_in(reset_line_in), .reset_line_out(reset_line_out),
  .reset_line_oe(reset_line_oe), .line_reset_level_bit(line_reset_level_bit),
  .lin_soft_transmit_bit(lin_soft_transmit_bit), .hold_bit(hold_bit), .lin_driver_en(lin_driver_en),
  .supply_invalid(supply_invalid), .force_active(force_active));
